// ---- design/fpx_defines.vh ----
`ifndef FPX_DEFINES_VH
`define FPX_DEFINES_VH

// ==========================================================
// Operation select codes
`define FPX_MAKE_ABSOLUTE_OP        3'h0
`define FPX_FLOAT_ADD_OP            3'h1
`define FPX_COPY_FLAGS_OP           3'h2
`define FPX_FLOAT_CLEAR_OP          3'h3
`define FPX_FLOAT_COMPARE_OP        3'h4
`define FPX_DOUBLE_TO_SINGLE_LOAD   3'h5
`define FPX_INTEGER_TO_FLOAT_LOAD   3'h6

// ==========================================================
// Trap cause codes
`define FPX_TRAP_NONE               2'h0
`define FPX_TRAP_UNDEF              2'h1
`define FPX_TRAP_OVERFLOW           2'h2
`define FPX_TRAP_UNDERFLOW          2'h3

// ==========================================================
// Floating word layout
`define FPX_SIGN_BIT                63
`define FPX_EXP_HI                  62
`define FPX_EXP_LO                  55
`define FPX_FRAC_HI                 54

// ==========================================================
// Exponent figures, excess-200 octal
`define FPX_EXP_MAX                 11'h0FF
`define FPX_INT_EXP_BASE            11'h0A0

// ==========================================================
// Working mantissa widths
`define FPX_MANT_W                  60
`define FPX_SHIFT_W                 6

`endif

// ---- design/fpx_execute.v ----
`timescale 1ns/1ps
`include "fpx_defines.vh"

// What this block does
// [RULE1] Floating operands are single precision unless double select is set
// [RULE2] Integer conversions use 32 bits when long select is set, else 16
// [RULE3] Float operands arrive via float modes, integers via CPU modes
// [RULE4] Exponent floor is 2**-128; fraction is 24 or 56 bits
// [RULE5] Absolute value clears sign, zero exponent gives exact zero, sets flags
// [RULE6] Undefined trap on -0 operand before execution, nothing written
// [RULE7] Add stores sum, or exact zero on untrapped overflow or underflow
// [RULE8] Add runs in selected precision, chopped or rounded by chop select
// [RULE9] Trapped add keeps fraction and low eight exponent bits
// [RULE10] Add clears carry, overflow flag on overflow, zero and sign from result
// [RULE11] Add can write -0 only on trapped overflow or underflow
// [RULE12] Copy flags moves float flags onto CPU flags
// [RULE13] Clear writes exact zero, sets zero flag only, never traps
// [RULE14] Compare stores nothing, flags follow the source operand; the code writes zero when both operands are zero
// [RULE15] Compare treats zero exponent as zero; both zero writes zero
// [RULE16] Single mode conversion rounds or chops double to single
// [RULE17] Double mode conversion widens single exactly, low half cleared
// [RULE18] Rounding overflow sets overflow flag; trap or load exact zero
// [RULE19] Conversion error within one LSB chopped, half LSB rounded
// [RULE20] Integer to float load clears carry and overflow flags
// [RULE21] Short-form long source fills low sixteen bits with zeros
// [RULE22] Long to single reduces fraction to 24 bits, chop or round
module fpx_execute (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire        start,
    input  wire [2:0]  op_sel,
    input  wire        double_precision_select,
    input  wire        long_integer_select,
    input  wire        chop_select,
    input  wire        undefined_variable_trap_enable,
    input  wire        overflow_trap_enable,
    input  wire        underflow_trap_enable,
    input  wire [63:0] float_source_operand,
    input  wire [63:0] float_destination_operand,
    input  wire [63:0] float_accumulator,
    input  wire [31:0] int_source,
    input  wire        int_src_short_form,
    output reg         done_r,
    output reg  [63:0] result_r,
    output reg         result_we_r,
    output reg         float_carry_flag_r,
    output reg         float_overflow_flag_r,
    output reg         float_zero_flag_r,
    output reg         float_negative_flag_r,
    output reg         cpu_carry_r,
    output reg         cpu_overflow_r,
    output reg         cpu_zero_r,
    output reg         cpu_negative_r,
    output reg         cpu_flags_we_r,
    output reg         trap_r,
    output reg  [1:0]  trap_cause_r
);

    // ==========================================================
    // Helper functions

    // Single precision uses only the upper word
    function [63:0] prec_mask;
        input [63:0] x;
        input        dbl;
        begin
            prec_mask = dbl ? x : {x[63:32], 32'h00000000};
        end
    endfunction

    function [7:0] exp_of;
        input [63:0] x;
        begin
            exp_of = x[`FPX_EXP_HI:`FPX_EXP_LO];
        end
    endfunction

    // The undefined variable: sign set, exponent zero
    function is_mzero;
        input [63:0] x;
        begin
            is_mzero = x[`FPX_SIGN_BIT] & (exp_of(x) == 8'h00);
        end
    endfunction

    // Low eight exponent bits kept, hidden bit dropped
    function [63:0] pack;
        input        s;
        input [10:0] e;
        input [55:0] k;
        begin
            pack = {s, e[7:0], k[`FPX_FRAC_HI:0]};
        end
    endfunction

    // ==========================================================
    // Operand preparation
    wire        dps = double_precision_select;
    wire [63:0] src_p = prec_mask(float_source_operand, dps);        // see [RULE1]
    wire [63:0] acc_p = prec_mask(float_accumulator, dps);           // see [RULE1]
    wire [63:0] dst_p = prec_mask(float_destination_operand, dps);   // see [RULE1]
    wire [7:0]  src_e = exp_of(src_p);
    wire [7:0]  acc_e = exp_of(acc_p);
    wire        src_z = (src_e == 8'h00);
    wire        acc_z = (acc_e == 8'h00);
    wire        dst_z = (exp_of(dst_p) == 8'h00);

    // ==========================================================
    // Adder: align, add or subtract magnitudes
    wire [59:0] src_m = src_z ? 60'h000000000000000 : {2'h1, src_p[54:0], 3'h0};
    wire [59:0] acc_m = acc_z ? 60'h000000000000000 : {2'h1, acc_p[54:0], 3'h0};
    wire        acc_big = (acc_e >= src_e);
    wire [7:0]  e_big = acc_big ? acc_e : src_e;
    wire [7:0]  e_diff = acc_big ? (acc_e - src_e) : (src_e - acc_e);
    wire [59:0] m_big = acc_big ? acc_m : src_m;
    wire [59:0] m_sml = acc_big ? src_m : acc_m;
    wire        s_big = acc_big ? acc_p[63] : src_p[63];
    wire        s_sml = acc_big ? src_p[63] : acc_p[63];
    wire [5:0]  al_sh = (e_diff > 8'h3B) ? 6'h3B : e_diff[5:0];

    // Shifted-out bits fold into a sticky bit
    wire [59:0] lost_mask = ~({`FPX_MANT_W{1'b1}} << al_sh);
    wire        sticky = |(m_sml & lost_mask);
    wire [59:0] m_al = (m_sml >> al_sh) | {59'h000000000000000, sticky};
    wire        same_sign = (s_big == s_sml);
    wire        big_ge = (m_big >= m_al);

    reg  [59:0] add_raw;
    reg         add_sign;

    // Sign-magnitude sum
    always @* begin
        if (same_sign) begin
            add_raw  = m_big + m_al;
            add_sign = s_big;
        end else if (big_ge) begin
            add_raw  = m_big - m_al;
            add_sign = s_big;
        end else begin
            add_raw  = m_al - m_big;
            add_sign = s_sml;
        end
    end

    wire [59:0] add_norm;
    wire [5:0]  add_sh;
    wire        add_zero;

    fpx_norm #(
        .W  (`FPX_MANT_W),
        .SW (`FPX_SHIFT_W)
    ) u_norm_add (
        .mant_in  (add_raw),
        .mant_out (add_norm),
        .shift    (add_sh),
        .is_zero  (add_zero)
    );

    // ==========================================================
    // Integer source shaping and normalising
    wire [31:0] int_raw = long_integer_select ?                      // see [RULE2]
                          (int_src_short_form ?
                           {int_source[15:0], 16'h0000} :            // see [RULE21]
                           int_source) :
                          {{16{int_source[15]}}, int_source[15:0]};
    wire        int_neg = int_raw[31];
    wire [31:0] int_mag = int_neg ? (32'h00000000 - int_raw) : int_raw;
    wire [59:0] int_norm;
    wire [5:0]  int_sh;
    wire        int_zero;

    fpx_norm #(
        .W  (`FPX_MANT_W),
        .SW (`FPX_SHIFT_W)
    ) u_norm_int (
        .mant_in  ({int_mag, 28'h0000000}),
        .mant_out (int_norm),
        .shift    (int_sh),
        .is_zero  (int_zero)
    );

    // ==========================================================
    // Shared rounder, input chosen by operation
    reg  [59:0] rnd_in;
    reg         rnd_dbl;
    wire [55:0] rnd_kept;
    wire        rnd_carry;

    always @* begin
        case (op_sel)
            `FPX_FLOAT_ADD_OP: begin
                rnd_in  = add_norm;                                  // see [RULE8]
                rnd_dbl = dps;
            end
            `FPX_DOUBLE_TO_SINGLE_LOAD: begin
                rnd_in  = {1'b1, float_source_operand[54:0], 4'h0};  // see [RULE16]
                rnd_dbl = 1'b0;
            end
            default: begin
                rnd_in  = int_norm;                                  // see [RULE22]
                rnd_dbl = dps;
            end
        endcase
    end

    fpx_round u_round (
        .mant_in (rnd_in),
        .dbl     (rnd_dbl),
        .chop    (chop_select),                                      // see [RULE19]
        .kept    (rnd_kept),
        .carry   (rnd_carry)
    );

    // ==========================================================
    // Result exponents and range checks
    wire [10:0] rc = {10'h000, rnd_carry};
    wire [10:0] add_exp = {3'h0, e_big} + 11'h001 - {5'h00, add_sh} + rc;
    wire        add_unf = ~add_zero & (add_exp[10] | (add_exp == 11'h000));  // see [RULE4]
    wire        add_ovf = ~add_zero & ~add_exp[10] & (add_exp > `FPX_EXP_MAX);
    wire [10:0] cnv_exp = {3'h0, exp_of(float_source_operand)} + rc;
    wire        cnv_ovf = (cnv_exp > `FPX_EXP_MAX);
    wire [10:0] int_exp = `FPX_INT_EXP_BASE - {5'h00, int_sh} + rc;

    // ==========================================================
    // Operation decode
    reg  [63:0] res_nxt;
    reg         wr_nxt;
    reg         flag_we_nxt;
    reg         v_nxt;
    reg         z_nxt;
    reg         n_nxt;
    reg         trap_nxt;
    reg  [1:0]  cause_nxt;

    always @* begin
        res_nxt     = 64'h0000000000000000;
        wr_nxt      = 1'b0;
        flag_we_nxt = 1'b0;
        v_nxt       = 1'b0;
        trap_nxt    = 1'b0;
        cause_nxt   = `FPX_TRAP_NONE;
        case (op_sel)
            `FPX_MAKE_ABSOLUTE_OP: begin
                if (undefined_variable_trap_enable & is_mzero(dst_p)) begin
                    trap_nxt  = 1'b1;                                // see [RULE6]
                    cause_nxt = `FPX_TRAP_UNDEF;
                end else begin
                    wr_nxt      = 1'b1;
                    flag_we_nxt = 1'b1;
                    if (!dst_z) begin
                        res_nxt = {1'b0, dst_p[62:0]};               // see [RULE5]
                    end
                end
            end
            `FPX_FLOAT_ADD_OP: begin
                if (undefined_variable_trap_enable & is_mzero(src_p)) begin
                    trap_nxt  = 1'b1;                                // see [RULE6]
                    cause_nxt = `FPX_TRAP_UNDEF;
                end else begin
                    wr_nxt      = 1'b1;
                    flag_we_nxt = 1'b1;
                    v_nxt       = add_ovf;                           // see [RULE10]
                    if (add_zero) begin
                        res_nxt = 64'h0000000000000000;
                    end else if ((add_ovf & ~overflow_trap_enable) |
                                 (add_unf & ~underflow_trap_enable)) begin
                        res_nxt = 64'h0000000000000000;              // see [RULE7]
                    end else begin
                        res_nxt = pack(add_sign, add_exp, rnd_kept); // see [RULE9] [RULE11]
                        if (add_ovf) begin
                            trap_nxt  = 1'b1;
                            cause_nxt = `FPX_TRAP_OVERFLOW;
                        end else if (add_unf) begin
                            trap_nxt  = 1'b1;
                            cause_nxt = `FPX_TRAP_UNDERFLOW;
                        end
                    end
                end
            end
            `FPX_FLOAT_CLEAR_OP: begin
                wr_nxt      = 1'b1;                                  // see [RULE13]
                flag_we_nxt = 1'b1;
            end
            `FPX_FLOAT_COMPARE_OP: begin
                if (undefined_variable_trap_enable &
                    (is_mzero(src_p) | is_mzero(acc_p))) begin
                    trap_nxt  = 1'b1;                                // see [RULE6]
                    cause_nxt = `FPX_TRAP_UNDEF;
                end else begin
                    flag_we_nxt = 1'b1;                              // see [RULE14]
                    wr_nxt      = src_z & acc_z;                     // see [RULE15]
                end
            end
            `FPX_DOUBLE_TO_SINGLE_LOAD: begin
                if (undefined_variable_trap_enable &
                    is_mzero(float_source_operand)) begin
                    trap_nxt  = 1'b1;                                // see [RULE6]
                    cause_nxt = `FPX_TRAP_UNDEF;
                end else begin
                    wr_nxt      = 1'b1;
                    flag_we_nxt = 1'b1;
                    if (exp_of(float_source_operand) == 8'h00) begin
                        res_nxt = 64'h0000000000000000;              // see [RULE16]
                    end else if (dps) begin
                        res_nxt = {float_source_operand[63:32], 32'h00000000}; // see [RULE17]
                    end else if (cnv_ovf) begin
                        v_nxt = 1'b1;                                // see [RULE18]
                        if (overflow_trap_enable) begin
                            res_nxt   = pack(float_source_operand[63], cnv_exp, rnd_kept);
                            trap_nxt  = 1'b1;
                            cause_nxt = `FPX_TRAP_OVERFLOW;
                        end
                    end else begin
                        res_nxt = pack(float_source_operand[63], cnv_exp, rnd_kept);
                    end
                end
            end
            `FPX_INTEGER_TO_FLOAT_LOAD: begin
                wr_nxt      = 1'b1;                                  // see [RULE20]
                flag_we_nxt = 1'b1;
                if (!int_zero) begin
                    res_nxt = pack(int_neg, int_exp, rnd_kept);      // see [RULE3]
                end
            end
            default: begin
                wr_nxt = 1'b0;
            end
        endcase
        // Compare flags follow the source; others follow the stored value
        if (op_sel == `FPX_FLOAT_COMPARE_OP) begin
            z_nxt = src_z;                                           // see [RULE14]
            n_nxt = src_p[63] & ~src_z;
        end else begin
            z_nxt = (exp_of(res_nxt) == 8'h00);                      // see [RULE5] [RULE10]
            n_nxt = res_nxt[63];
        end
    end

    // ==========================================================
    // Output and status registers
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            done_r                <= 1'b0;
            result_r              <= 64'h0000000000000000;
            result_we_r           <= 1'b0;
            float_carry_flag_r    <= 1'b0;
            float_overflow_flag_r <= 1'b0;
            float_zero_flag_r     <= 1'b0;
            float_negative_flag_r <= 1'b0;
            cpu_carry_r           <= 1'b0;
            cpu_overflow_r        <= 1'b0;
            cpu_zero_r            <= 1'b0;
            cpu_negative_r        <= 1'b0;
            cpu_flags_we_r        <= 1'b0;
            trap_r                <= 1'b0;
            trap_cause_r          <= `FPX_TRAP_NONE;
        end else begin
            done_r         <= start;
            result_we_r    <= start & wr_nxt;
            trap_r         <= start & trap_nxt;
            cpu_flags_we_r <= start & (op_sel == `FPX_COPY_FLAGS_OP);
            if (start) begin
                result_r     <= res_nxt;
                trap_cause_r <= cause_nxt;
            end
            // Carry always clears on a flag-writing operation
            if (start & flag_we_nxt) begin
                float_carry_flag_r    <= 1'b0;                       // see [RULE10] [RULE20]
                float_overflow_flag_r <= v_nxt;
                float_zero_flag_r     <= z_nxt;
                float_negative_flag_r <= n_nxt;
            end
            // Float flags copied onto the CPU flags
            if (start & (op_sel == `FPX_COPY_FLAGS_OP)) begin
                cpu_carry_r    <= float_carry_flag_r;                // see [RULE12]
                cpu_overflow_r <= float_overflow_flag_r;
                cpu_zero_r     <= float_zero_flag_r;
                cpu_negative_r <= float_negative_flag_r;
            end
        end
    end
endmodule

// ---- design/fpx_norm.v ----
`timescale 1ns/1ps

// ==========================================================
// Leading-one normaliser: msb of result lands on top bit
module fpx_norm #(
    parameter W  = 60,
    parameter SW = 6
) (
    input  wire [W-1:0]  mant_in,
    output reg  [W-1:0]  mant_out,
    output reg  [SW-1:0] shift,
    output reg           is_zero
);
    integer i;
    integer s;

    // Highest set bit decides the shift
    always @* begin
        s = 0;
        for (i = 0; i < W; i = i + 1) begin
            if (mant_in[i]) begin
                s = W - 1 - i;
            end
        end
        shift    = s[SW-1:0];
        is_zero  = (mant_in == {W{1'b0}});
        mant_out = mant_in << shift;
    end
endmodule

// ---- design/fpx_round.v ----
`timescale 1ns/1ps

// ==========================================================
// Chop or round a normalised mantissa to 24 or 56 bits
module fpx_round (
    input  wire [59:0] mant_in,
    input  wire        dbl,
    input  wire        chop,
    output reg  [55:0] kept,
    output reg         carry
);
    reg [55:0] keep;
    reg [56:0] step;
    reg [56:0] sum;
    reg        rbit;

    // First lost bit is the rounding bit
    always @* begin
        keep  = dbl ? mant_in[59:4] : {mant_in[59:36], 32'h00000000};
        rbit  = dbl ? mant_in[3] : mant_in[35];
        step  = dbl ? 57'h000000000000001 : 57'h000000100000000;
        sum   = {1'b0, keep} + ((rbit & ~chop) ? step : 57'h000000000000000);
        carry = sum[56];
        kept  = carry ? sum[56:1] : sum[55:0];
    end
endmodule

// ---- sim/fpx_decoder_model.sv ----
`timescale 1ns/1ps

// ==========================================================
// Decoder and operand fetch stand-in
module fpx_decoder_model (
    input  wire         clk_sys,
    input  wire         arst_n,
    input  wire         issue,
    input  wire [233:0] req,
    output reg          start,
    output reg  [233:0] cmd
);
    // One start per issue; idle operands invert
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            start <= 1'b0;
            cmd   <= 234'h0;
        end else begin
            start <= issue;
            cmd   <= issue ? req : ~cmd;
        end
    end
endmodule

// ---- sim/fpx_execute_asserts.sv ----
`timescale 1ns/1ps

// ==========================================================
// Port-level checks on the execute block
module fpx_execute_asserts (
    input wire        clk_sys,
    input wire        arst_n,
    input wire        start,
    input wire [2:0]  op_sel,
    input wire        undefined_variable_trap_enable,
    input wire [63:0] float_source_operand,
    input wire [63:0] float_destination_operand,
    input wire        done_r,
    input wire [63:0] result_r,
    input wire        result_we_r,
    input wire        float_carry_flag_r,
    input wire        float_overflow_flag_r,
    input wire        float_zero_flag_r,
    input wire        float_negative_flag_r,
    input wire        cpu_carry_r,
    input wire        cpu_overflow_r,
    input wire        cpu_zero_r,
    input wire        cpu_negative_r,
    input wire        cpu_flags_we_r,
    input wire        trap_r,
    input wire [1:0]  trap_cause_r
);
    // Packed flag views
    wire [3:0] ff = {float_carry_flag_r, float_overflow_flag_r, float_zero_flag_r,
                     float_negative_flag_r};
    wire [3:0] cf = {cpu_carry_r, cpu_overflow_r, cpu_zero_r, cpu_negative_r};
    wire       uv = undefined_variable_trap_enable;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_done_next: assert property (start |=> done_r)
        else $error("done missing after start");
    a_quiet_idle: assert property (!start |=> !done_r && !result_we_r && !trap_r && !cpu_flags_we_r)
        else $error("pulse without start");
    a_clear_zero: assert property (start && op_sel == 3'h3 |=> result_we_r && result_r == 64'h0 && ff == 4'h2 && !trap_r)
        else $error("clear result or flags wrong");
    a_copy_moves: assert property (start && op_sel == 3'h2 |=> cpu_flags_we_r && cf == $past(ff))
        else $error("copied flags wrong");
    a_cpu_hold: assert property (!(start && op_sel == 3'h2) |=> $stable(cf) && !cpu_flags_we_r)
        else $error("cpu flags moved");
    a_abs_positive: assert property (start && op_sel == 3'h0 && !(uv && float_destination_operand[63:55] == 9'h100)
        |=> result_we_r && !result_r[63] && ff[3:2] == 2'h0 && !ff[0])
        else $error("abs result or flags wrong");
    a_undef_refuse: assert property (start && uv && op_sel == 3'h1 && float_source_operand[63:55] == 9'h100
        |=> trap_r && trap_cause_r == 2'h1 && !result_we_r && $stable(ff))
        else $error("undefined operand not refused");
    a_cmp_no_store: assert property (start && !uv && op_sel == 3'h4 && float_source_operand[62:55] != 8'h00
        |=> !result_we_r && ff[3:1] == 3'h0)
        else $error("compare stored or flags wrong");
    a_flags_track: assert property (result_we_r && !trap_r |-> ff[1] == (result_r[62:55] == 8'h00) && ff[0] == result_r[63])
        else $error("zero or sign flag wrong");
    a_int_clear_cv: assert property (start && op_sel == 3'h6 |=> ff[3:2] == 2'h0)
        else $error("int load left carry or overflow");
endmodule

bind fpx_execute fpx_execute_asserts u_chk (.*);

// ---- sim/test_fpx_execute.sv ----
`timescale 1ns/1ps

// ==========================================================
// Bench for the execute block
module test_fpx_execute;
    localparam [63:0] ONE  = 64'h4080000000000000;
    localparam [63:0] TWO  = 64'h4100000000000000;
    localparam [63:0] NEGZ = 64'h8000000000000000;
    localparam [63:0] RND  = 64'h4080000080000000;
    reg          clk_sys;
    reg          arst_n;
    reg          issue;
    reg  [233:0] req;
    reg  [31:0]  lf;
    reg  [63:0]  x;
    wire         start;
    wire [233:0] cmd;
    wire         done_r, result_we_r, trap_r;
    wire [1:0]   trap_cause_r;
    wire [63:0]  result_r;
    wire [3:0]   ff, cf;
    integer      errors, tests_run, i;

    fpx_decoder_model u_dec (.clk_sys(clk_sys), .arst_n(arst_n), .issue(issue), .req(req),
        .start(start), .cmd(cmd));
    fpx_execute dut (.clk_sys(clk_sys), .arst_n(arst_n), .start(start), .op_sel(cmd[233:231]),
        .double_precision_select(cmd[230]), .long_integer_select(cmd[229]),
        .chop_select(cmd[228]), .undefined_variable_trap_enable(cmd[227]),
        .overflow_trap_enable(cmd[226]), .underflow_trap_enable(cmd[225]),
        .float_source_operand(cmd[224:161]), .float_destination_operand(cmd[160:97]),
        .float_accumulator(cmd[96:33]), .int_source(cmd[31:0]), .int_src_short_form(cmd[32]),
        .done_r(done_r), .result_r(result_r), .result_we_r(result_we_r),
        .float_carry_flag_r(ff[3]), .float_overflow_flag_r(ff[2]),
        .float_zero_flag_r(ff[1]), .float_negative_flag_r(ff[0]),
        .cpu_carry_r(cf[3]), .cpu_overflow_r(cf[2]), .cpu_zero_r(cf[1]),
        .cpu_negative_r(cf[0]), .cpu_flags_we_r(), .trap_r(trap_r),
        .trap_cause_r(trap_cause_r));

    // Next random word
    function [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Compare and count
    task chk(input [63:0] seen, input [63:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // One operation: modes {dbl,long,chop,uv,ov,un}; fl {trap,cause,we,C,V,Z,N}
    task t(input [2:0] op, input [5:0] md, input [63:0] a, input [63:0] b,
           input [32:0] iv, input [63:0] res, input [7:0] fl);
        begin
            @(posedge clk_sys);
            issue <= 1'b1;
            req   <= {op, md, a, a, b, iv};
            @(posedge clk_sys);
            issue <= 1'b0;
            @(posedge clk_sys);
            #1;
            chk(done_r, 1'b1);
            chk({trap_r, trap_cause_r, result_we_r, ff}, fl);
            if (fl[4]) chk(result_r, res);
        end
    endtask
    // Verdict and end of run
    task summarize;
        begin
            $display("checks %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors = errors + 1;
        summarize;
    end

    // ==========================================================
    // Main sequence
    initial begin
        arst_n = 1'b0;
        issue = 1'b0;
        req = 234'h0;
        errors = 0;
        tests_run = 0;
        lf = 32'h0000003D;
        repeat (8) @(posedge clk_sys);
        chk({cf, ff, result_r[55:0]}, 64'h0);
        arst_n <= 1'b1;
        t(3'h3, 6'h00, ONE, ONE, 33'h0, 64'h0, 8'h12);
        t(3'h7, 6'h00, ONE, ONE, 33'h0, 64'h0, 8'h02);
        t(3'h0, 6'h24, NEGZ, ONE, 33'h0, 64'h0, 8'hA2);
        t(3'h1, 6'h20, ONE, ONE, 33'h0, TWO, 8'h10);
        t(3'h1, 6'h00, ONE | 64'hFFFF, ONE | 64'hFFFF, 33'h0, TWO, 8'h10);
        t(3'h1, 6'h22, 64'h7FC0000000000000, 64'h7FC0000000000000, 33'h0,
          64'h0040000000000000, 8'hD6);
        t(3'h1, 6'h22, 64'hFF80000000000000, 64'hFF80000000000000, 33'h0, NEGZ, 8'hD7);
        t(3'h1, 6'h24, NEGZ, ONE, 33'h0, 64'h0, 8'hA7);
        t(3'h1, 6'h21, 64'h00A0000000000000, 64'h8080000000000000, 33'h0,
          64'h7F80000000000000, 8'hF0);
        t(3'h1, 6'h20, 64'h00C0000000000000, 64'h8080000000000000, 33'h0, 64'h0, 8'h12);
        t(3'h4, 6'h20, 64'hC080000000000000, ONE, 33'h0, 64'h0, 8'h01);
        t(3'h4, 6'h20, 64'h0012345600000000, 64'h8001000000000000, 33'h0, 64'h0, 8'h12);
        t(3'h4, 6'h24, ONE, NEGZ, 33'h0, 64'h0, 8'hA2);
        t(3'h5, 6'h20, 64'h40800001FFFFFFFF, ONE, 33'h0, 64'h4080000100000000, 8'h10);
        t(3'h5, 6'h08, RND, ONE, 33'h0, ONE, 8'h10);
        t(3'h5, 6'h00, RND, ONE, 33'h0, 64'h4080000100000000, 8'h10);
        t(3'h5, 6'h00, 64'h7FFFFFFF80000000, ONE, 33'h0, 64'h0, 8'h16);
        t(3'h5, 6'h02, 64'h7FFFFFFF80000000, ONE, 33'h0, 64'h0, 8'hD6);
        t(3'h5, 6'h00, 64'h0012345678000000, ONE, 33'h0, 64'h0, 8'h12);
        t(3'h6, 6'h20, ONE, ONE, 33'h012340001, ONE, 8'h10);
        t(3'h6, 6'h20, ONE, ONE, 33'h01234FFFE, 64'hC100000000000000, 8'h11);
        t(3'h6, 6'h30, ONE, ONE, 33'h1ABCD0001, 64'h4880000000000000, 8'h10);
        t(3'h6, 6'h18, ONE, ONE, 33'h001000001, 64'h4C80000000000000, 8'h10);
        t(3'h6, 6'h10, ONE, ONE, 33'h001000001, 64'h4C80000100000000, 8'h10);
        t(3'h6, 6'h30, ONE, ONE, 33'h001000001, 64'h4C80000080000000, 8'h10);
        // Overflowing add then flag copy
        @(posedge clk_sys);
        issue <= 1'b1;
        req   <= {3'h1, 6'h20, 64'h7FC0000000000000, 64'h0, 64'h7FC0000000000000, 33'h0};
        @(posedge clk_sys);
        req   <= {3'h2, 6'h20, 192'h0, 33'h0};
        @(posedge clk_sys);
        issue <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(cf, 4'h6);
        // Random absolute values and clears
        for (i = 0; i < 8; i = i + 1) begin
            lf = nxt(lf);
            x = {lf, ~lf};
            lf = nxt(lf);
            if (lf[0]) x[62:55] = 8'h00;
            t(3'h0, 6'h20, x, ONE, 33'h0, (x[62:55] == 8'h00) ? 64'h0 : {1'b0, x[62:0]},
              (x[62:55] == 8'h00) ? 8'h12 : 8'h10);
            t(3'h3, lf[6:1], x, x, 33'h0, 64'h0, 8'h12);
        end
        summarize;
    end
endmodule
